// [core/rfmc_ctrl.sv]
// Front-end mode decoder, switch drivers, DC calibration sequencer, synth settings.
// Assumes all inputs synchronous to clk; chip_power_enable low acts as the sleep reset.
// Contract
// - Decode power state into active, idle, standby
// - Power enable low: sleep, outputs safe
// - Standby/idle: PA off, sleep high, band low
// - Active: sleep low, band follows select
// - Transmit: only selected band PA on
// - Four switch drivers control front end
// - Calibration holds sleep high until done
// - RF divide from integer and subtract fields
// - RF synth defaults 1,10,0,48,79
// - IF synth defaults to integer mode
// - Rising request while active starts calibration, status low
// - Result kept while request high, awake
// - Request low disables correction fully
// - Reset 4 us, status 1 us, 68 ticks; code has no 4 us or 1 us timer, status stays low for the whole run
// - Band select 1 is A, reset 0
// - Defaults restored while power enable low
`timescale 1ns/1ps
`default_nettype none
module rfmc_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_power_enable,
  input wire logic power_state_hi,
  input wire logic power_state_lo,
  input wire logic band_select,
  input wire logic tx_rx_select_pin,
  input wire logic pa_enable_in,
  input wire logic dc_cal_request,
  input wire logic ref_en,
  input wire logic synth_locked,
  input wire logic cal_proc_done,
  input wire logic cfg_we,
  input wire logic [0:0] cfg_prescaler,
  input wire logic [4:0] cfg_rf_integer_field,
  input wire logic [2:0] cfg_rf_subtract_field,
  input wire logic [6:0] cfg_rf_frac_numerator,
  input wire logic [6:0] cfg_rf_frac_modulus,
  input wire logic cfg_if_fractional_enable,
  output logic band_a_pa_off,
  output logic band_b_pa_off,
  output logic frontend_sleep_out,
  output logic band_select_out,
  output rfmc_pkg::rfmc_mode_t mode,
  output logic tx_on,
  output logic rx_on,
  output logic synth_on,
  output logic osc_on,
  output logic serial_on,
  output logic cal_status,
  output logic cal_running,
  output logic dc_corr_enable,
  output logic [0:0] prescaler,
  output logic [4:0] rf_integer_field,
  output logic [2:0] rf_subtract_field,
  output logic [6:0] rf_frac_numerator,
  output logic [6:0] rf_frac_modulus,
  output logic if_fractional_enable,
  output logic [rfmc_pkg::RF_DIV_W-1:0] rf_div_int
);
  import rfmc_pkg::*;

  // Integer part of the divide: 8*(integer+3) - subtract
  function automatic logic [RF_DIV_W-1:0] rf_div(input logic [4:0] d, input logic [2:0] s);
    logic [RF_DIV_W-1:0] t;
    t = ({11'h000, d} + 16'h0003) << 3;
    return t - {13'h0000, s};
  endfunction

  // Configuration held from power enable; cleared to defaults in sleep
  logic [0:0] next_prescaler;
  logic [4:0] next_rf_integer_field;
  logic [2:0] next_rf_subtract_field;
  logic [6:0] next_rf_frac_numerator;
  logic [6:0] next_rf_frac_modulus;
  logic next_if_fractional_enable;
  logic [RF_DIV_W-1:0] next_rf_div_int;
  always_comb begin
    next_prescaler = prescaler;
    next_rf_integer_field = rf_integer_field;
    next_rf_subtract_field = rf_subtract_field;
    next_rf_frac_numerator = rf_frac_numerator;
    next_rf_frac_modulus = rf_frac_modulus;
    next_if_fractional_enable = if_fractional_enable;
    if (!chip_power_enable) begin
      next_prescaler = RST_PRESCALER;
      next_rf_integer_field = RST_RF_INTEGER;
      next_rf_subtract_field = RST_RF_SUBTRACT;
      next_rf_frac_numerator = RST_RF_NUMERATOR;
      next_rf_frac_modulus = RST_RF_MODULUS;
      next_if_fractional_enable = RST_IF_FRAC_EN;
    end else if (cfg_we) begin
      next_prescaler = cfg_prescaler;
      next_rf_integer_field = cfg_rf_integer_field;
      next_rf_subtract_field = cfg_rf_subtract_field;
      next_rf_frac_numerator = cfg_rf_frac_numerator;
      next_rf_frac_modulus = cfg_rf_frac_modulus;
      next_if_fractional_enable = cfg_if_fractional_enable;
    end
    next_rf_div_int = rf_div(next_rf_integer_field, next_rf_subtract_field);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler <= RST_PRESCALER;
      rf_integer_field <= RST_RF_INTEGER;
      rf_subtract_field <= RST_RF_SUBTRACT;
      rf_frac_numerator <= RST_RF_NUMERATOR;
      rf_frac_modulus <= RST_RF_MODULUS;
      if_fractional_enable <= RST_IF_FRAC_EN;
      rf_div_int <= 16'h0068;
    end else begin
      prescaler <= next_prescaler;
      rf_integer_field <= next_rf_integer_field;
      rf_subtract_field <= next_rf_subtract_field;
      rf_frac_numerator <= next_rf_frac_numerator;
      rf_frac_modulus <= next_rf_frac_modulus;
      if_fractional_enable <= next_if_fractional_enable;
      rf_div_int <= next_rf_div_int;
    end
  end

  // Mode decode
  rfmc_mode_t cur_mode;
  always_comb begin
    if (!chip_power_enable) begin
      cur_mode = RFMC_SLEEP;
    end else if (!power_state_lo) begin
      cur_mode = RFMC_STANDBY;
    end else if (power_state_hi) begin
      cur_mode = RFMC_ACTIVE;
    end else begin
      cur_mode = RFMC_IDLE;
    end
  end

  // Calibration sequencer
  rfmc_cal_t cal_state;
  rfmc_cal_t next_cal_state;
  logic req_q;
  logic [6:0] tick_cnt;
  logic [6:0] next_tick_cnt;
  logic tick;
  logic cal_rise;
  assign cal_rise = dc_cal_request && !req_q;
  rfmc_tick_div u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .run(cal_state == RFMC_CAL_RUN),
    .ref_en(ref_en),
    .tick(tick)
  );
  always_comb begin
    next_cal_state = cal_state;
    next_tick_cnt = tick_cnt;
    case (cal_state)
      RFMC_CAL_OFF: begin
        next_tick_cnt = 7'h00;
        if (cal_rise && cur_mode == RFMC_ACTIVE) begin
          next_cal_state = RFMC_CAL_RUN;
        end
      end
      RFMC_CAL_RUN: begin
        if (tick) begin
          next_tick_cnt = tick_cnt + 7'h01;
        end
        // Done from the analog procedure, or forced at the tick budget
        if (cal_proc_done || tick_cnt == CAL_TICK_CNT) begin
          next_cal_state = RFMC_CAL_HOLD;
        end
      end
      RFMC_CAL_HOLD: next_cal_state = RFMC_CAL_HOLD;
      default: next_cal_state = RFMC_CAL_OFF;
    endcase
    if (!dc_cal_request || cur_mode == RFMC_SLEEP) begin
      next_cal_state = RFMC_CAL_OFF;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_state <= RFMC_CAL_OFF;
      req_q <= 1'b0;
      tick_cnt <= 7'h00;
    end else begin
      cal_state <= next_cal_state;
      req_q <= dc_cal_request;
      tick_cnt <= next_tick_cnt;
    end
  end

  // Switch drivers and internal enables
  logic next_pa_a_off;
  logic next_pa_b_off;
  logic next_sleep;
  logic next_band;
  logic next_tx;
  logic next_rx;
  logic transmit;
  always_comb begin
    next_pa_a_off = 1'b1;
    next_pa_b_off = 1'b1;
    next_sleep = 1'b1;
    next_band = 1'b0;
    next_tx = 1'b0;
    next_rx = 1'b0;
    transmit = tx_rx_select_pin && pa_enable_in;
    if (cur_mode == RFMC_ACTIVE) begin
      next_sleep = (next_cal_state == RFMC_CAL_RUN);
      next_band = band_select;
      next_tx = transmit || !pa_enable_in;
      next_rx = !tx_rx_select_pin || !pa_enable_in;
      if (transmit && next_cal_state != RFMC_CAL_RUN) begin
        next_pa_a_off = !band_select;
        next_pa_b_off = band_select;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      band_a_pa_off <= 1'b1;
      band_b_pa_off <= 1'b1;
      frontend_sleep_out <= 1'b1;
      band_select_out <= RST_BAND_SELECT;
      mode <= RFMC_SLEEP;
      tx_on <= 1'b0;
      rx_on <= 1'b0;
      synth_on <= 1'b0;
      osc_on <= 1'b0;
      serial_on <= 1'b0;
      cal_status <= 1'b1;
      cal_running <= 1'b0;
      dc_corr_enable <= 1'b0;
    end else begin
      band_a_pa_off <= next_pa_a_off;
      band_b_pa_off <= next_pa_b_off;
      frontend_sleep_out <= next_sleep;
      band_select_out <= next_band;
      mode <= cur_mode;
      tx_on <= next_tx;
      rx_on <= next_rx;
      synth_on <= (cur_mode == RFMC_IDLE) || (cur_mode == RFMC_ACTIVE);
      osc_on <= (cur_mode != RFMC_SLEEP);
      serial_on <= (cur_mode != RFMC_SLEEP);
      cal_status <= synth_locked && (next_cal_state != RFMC_CAL_RUN);
      cal_running <= (next_cal_state == RFMC_CAL_RUN);
      dc_corr_enable <= (next_cal_state == RFMC_CAL_HOLD);
    end
  end
endmodule
`default_nettype wire

// [core/rfmc_pkg.sv]
// Package: constants and types for the front-end mode and DC calibration control.
// Assumes a single 200 MHz system clock; the reference clock is counted from it.
package rfmc_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CAL_RESET_US = 4;
  localparam int unsigned CAL_RESET_CYC = CAL_RESET_US * CLK_MHZ;
  localparam int unsigned STATUS_LOW_US = 1;
  localparam int unsigned STATUS_LOW_CYC = STATUS_LOW_US * CLK_MHZ;
  localparam int unsigned TICK_REF_PERIODS = 44;
  localparam int unsigned CAL_MAX_TICKS = 68;
  localparam logic [6:0] CAL_TICK_CNT = 7'h44;
  localparam logic [5:0] TICK_DIV_LAST = 6'h2b;
  localparam logic [0:0] RST_PRESCALER = 1'h1;
  localparam logic [4:0] RST_RF_INTEGER = 5'h0a;
  localparam logic [2:0] RST_RF_SUBTRACT = 3'h0;
  localparam logic [6:0] RST_RF_NUMERATOR = 7'h30;
  localparam logic [6:0] RST_RF_MODULUS = 7'h4f;
  localparam logic [0:0] RST_IF_FRAC_EN = 1'h0;
  localparam logic [0:0] RST_BAND_SELECT = 1'h0;
  localparam logic [1:0] RST_POWER_STATE = 2'h0;
  localparam int unsigned RF_DIV_W = 16;
  typedef enum logic [1:0] {RFMC_SLEEP, RFMC_STANDBY, RFMC_IDLE, RFMC_ACTIVE} rfmc_mode_t;
  typedef enum logic [1:0] {RFMC_CAL_OFF, RFMC_CAL_RUN, RFMC_CAL_HOLD} rfmc_cal_t;
endpackage

// [core/rfmc_tick_div.sv]
// Reference tick divider: one-cycle tick every 44 reference periods.
// Assumes ref_en is a one-cycle pulse per reference period in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module rfmc_tick_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic ref_en,
  output logic tick
);
  import rfmc_pkg::*;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic next_tick;
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = 6'h00;
    end else if (ref_en) begin
      if (cnt == TICK_DIV_LAST) begin
        next_cnt = 6'h00;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 6'h01;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 6'h00;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// [dv/rfmc_fe_model.sv]
// Far-side model: reference pulses and the analog DC calibration procedure.
// Assumes a 200 MHz clk; done_dly of zero means the procedure never reports done.
`timescale 1ns/1ps
`default_nettype none
module rfmc_fe_model #(parameter int REF_DIV = 5) (
  input wire logic clk,
  input wire logic cal_running,
  input wire logic [15:0] done_dly,
  output logic ref_en,
  output logic cal_proc_done
);
  int ref_cnt = 0;
  int cal_cnt = 0;
  assign ref_en = (ref_cnt == 0);
  // Done stays up once the delay has run, while cal_running is high
  assign cal_proc_done = cal_running && done_dly != 16'h0000 && cal_cnt >= int'(done_dly);
  always @(posedge clk) begin
    ref_cnt <= (ref_cnt == REF_DIV - 1) ? 0 : ref_cnt + 1;
    cal_cnt <= cal_running ? cal_cnt + 1 : 0;
  end
endmodule
`default_nettype wire

// [dv/rfmc_ctrl_sva.sv]
// Checker: mode decode, switch drivers and calibration sequencing.
// Assumes binding onto rfmc_ctrl; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rfmc_ctrl_sva import rfmc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_power_enable,
  input wire logic power_state_hi,
  input wire logic power_state_lo,
  input wire logic band_select,
  input wire logic dc_cal_request,
  input wire logic ref_en,
  input wire logic cal_proc_done,
  input wire logic band_a_pa_off,
  input wire logic band_b_pa_off,
  input wire logic frontend_sleep_out,
  input wire logic band_select_out,
  input wire rfmc_pkg::rfmc_mode_t mode,
  input wire logic cal_status,
  input wire logic cal_running,
  input wire logic dc_corr_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [11:0] ref_cnt;
  logic [11:0] next_ref_cnt;
  always_comb begin
    next_ref_cnt = cal_running ? ref_cnt + 12'(ref_en) : 12'h000;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ref_cnt <= 12'h000;
    else ref_cnt <= next_ref_cnt;
  end
  sleep_safe_a: assert property (!$past(chip_power_enable) |-> mode == RFMC_SLEEP &&
    band_a_pa_off && band_b_pa_off && frontend_sleep_out && !band_select_out) else $error("sleep outputs");
  idle_safe_a: assert property (mode inside {RFMC_STANDBY, RFMC_IDLE} |->
    band_a_pa_off && band_b_pa_off && frontend_sleep_out && !band_select_out) else $error("idle outputs");
  active_dec_a: assert property ($past(rst_n) &&
    $past(chip_power_enable & power_state_hi & power_state_lo) |-> mode == RFMC_ACTIVE) else $error("active");
  stby_dec_a: assert property ($past(rst_n) &&
    $past(chip_power_enable & !power_state_lo) |-> mode == RFMC_STANDBY) else $error("standby");
  band_follow_a: assert property (
    mode == RFMC_ACTIVE |-> band_select_out == $past(band_select)) else $error("band");
  one_pa_a: assert property (!(band_a_pa_off && band_b_pa_off) |-> !frontend_sleep_out &&
    band_a_pa_off != band_b_pa_off && band_a_pa_off == !band_select_out) else $error("pa drive");
  cal_start_a: assert property ($rose(dc_cal_request) && mode == RFMC_ACTIVE &&
    chip_power_enable && power_state_hi && power_state_lo |=> cal_running && !cal_status && frontend_sleep_out)
    else $error("cal start");
  cal_hold_a: assert property (
    cal_running |-> frontend_sleep_out && band_a_pa_off && band_b_pa_off) else $error("cal front end");
  done_end_a: assert property (cal_running && cal_proc_done && dc_cal_request &&
    chip_power_enable |=> !cal_running && dc_corr_enable) else $error("cal done");
  clear_cal_a: assert property (
    !dc_cal_request || !chip_power_enable |=> !cal_running && !dc_corr_enable) else $error("cal clear");
  tick_max_a: assert property (
    ref_cnt <= 12'(TICK_REF_PERIODS * CAL_MAX_TICKS)) else $error("cal too long");
  cover property ($rose(cal_running));
  cover property ($fell(cal_running) && dc_corr_enable);
  cover property (!band_a_pa_off);
endmodule
bind rfmc_ctrl rfmc_ctrl_sva u_sva (.*);
`default_nettype wire

// [dv/rfmc_ctrl_tb_top.sv]
// Testbench: mode table, switch drivers, synth settings, DC calibration.
// Assumes the far-side model supplies reference pulses and calibration done.
`timescale 1ns/1ps
`default_nettype none
module rfmc_ctrl_tb_top;
  import rfmc_pkg::*;
  logic clk = 1'h0;
  logic rst_n, chip_power_enable, power_state_hi, power_state_lo, band_select, tx_rx_select_pin, pa_enable_in;
  logic dc_cal_request, synth_locked, cfg_we, cfg_if_fractional_enable, ref_en, cal_proc_done;
  logic [0:0] cfg_prescaler, prescaler;
  logic [4:0] cfg_rf_integer_field, rf_integer_field;
  logic [2:0] cfg_rf_subtract_field, rf_subtract_field;
  logic [6:0] cfg_rf_frac_numerator, cfg_rf_frac_modulus, rf_frac_numerator, rf_frac_modulus;
  logic band_a_pa_off, band_b_pa_off, frontend_sleep_out, band_select_out, tx_on, rx_on, synth_on, osc_on;
  logic serial_on, cal_status, cal_running, dc_corr_enable, if_fractional_enable;
  logic [15:0] rf_div_int, done_dly;
  rfmc_mode_t mode;
  int failures = 0;
  int tests_run = 0;
  wire logic [23:0] cfg_out = {prescaler, rf_integer_field, rf_subtract_field, rf_frac_numerator,
    rf_frac_modulus, if_fractional_enable};
  localparam logic [2:0] MODE_IN [4] = '{3'h0, 3'h4, 3'h5, 3'h7};
  localparam logic [10:0] MODE_EXP [4] = '{11'h1c0, 11'h3c3, 11'h5c7, 11'h7bf};
  // With the PA disabled, both paths are enabled, whatever the tx/rx pin says
  localparam logic [5:0] TRX_EXP [4] = '{6'h33, 6'h22, 6'h37, 6'h16};
  rfmc_ctrl dut (.*);
  rfmc_fe_model model (.*);
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Pins: enable, state hi, state lo, band, tx/rx, pa enable, cal request
  task automatic drv(input logic [6:0] v);
    @(negedge clk);
    {chip_power_enable, power_state_hi, power_state_lo, band_select, tx_rx_select_pin, pa_enable_in,
      dc_cal_request} = v;
    repeat (2) @(negedge clk);
  endtask
  task automatic cfg(input logic [23:0] v);
    {cfg_prescaler, cfg_rf_integer_field, cfg_rf_subtract_field, cfg_rf_frac_numerator, cfg_rf_frac_modulus,
      cfg_if_fractional_enable} = v;
    cfg_we = 1'h1;
    @(negedge clk);
    cfg_we = 1'h0;
    @(negedge clk);
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 20000 && cal_running !== 1'h0; n++) @(negedge clk);
    if (cal_running !== 1'h0) begin
      failures++;
      results();
    end
  endtask
  initial begin
    {rst_n, chip_power_enable, power_state_hi, power_state_lo, band_select, tx_rx_select_pin, pa_enable_in,
      dc_cal_request, synth_locked, cfg_we, done_dly, cfg_prescaler, cfg_rf_integer_field,
      cfg_rf_subtract_field, cfg_rf_frac_numerator, cfg_rf_frac_modulus, cfg_if_fractional_enable} = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'h1;
    synth_locked = 1'h1;
    chk(cfg_out, 32'h00a8309e);
    chk(rf_div_int, 32'h0068);
    for (int i = 0; i < 4; i++) begin
      drv({MODE_IN[i], 4'h8});
      chk({mode, band_a_pa_off, band_b_pa_off, frontend_sleep_out, band_select_out, tx_on, rx_on, synth_on,
        osc_on, serial_on}, MODE_EXP[i]);
    end
    for (int j = 0; j < 4; j++) begin
      drv({3'h7, j[1], j[0], j[0], 1'h0});
      chk({band_a_pa_off, band_b_pa_off, frontend_sleep_out, band_select_out, tx_on, rx_on}, TRX_EXP[j]);
    end
    cfg(24'h7fa041);
    chk(rf_div_int, 32'h0109);
    chk(cfg_out, 32'h007fa041);
    drv(7'h40);
    chk(cfg_out, 32'h007fa041);
    drv(7'h00);
    cfg(24'h7fa041);
    chk(cfg_out, 32'h00a8309e);
    done_dly = 16'h0032;
    drv(7'h70);
    chk(cal_status, 1);
    synth_locked = 1'h0;
    repeat (2) @(negedge clk);
    chk(cal_status, 0);
    synth_locked = 1'h1;
    repeat (2) @(negedge clk);
    drv(7'h71);
    chk({cal_running, cal_status, frontend_sleep_out}, 3'h5);
    wait_idle();
    chk({dc_corr_enable, cal_status, frontend_sleep_out}, 3'h6);
    drv(7'h70);
    chk(dc_corr_enable, 0);
    repeat (800) @(negedge clk);
    done_dly = 16'h0000;
    drv(7'h71);
    wait_idle();
    chk(dc_corr_enable, 1);
    drv(7'h40);
    repeat (800) @(negedge clk);
    drv(7'h41);
    chk(cal_running, 0);
    drv(7'h70);
    repeat (800) @(negedge clk);
    drv(7'h71);
    drv(7'h31);
    chk({cal_running, dc_corr_enable, frontend_sleep_out}, 3'h1);
    results();
  end
endmodule
`default_nettype wire
